// ===== src/tag_interrupt_mask_flags.sv
// interrupt flags and masks of a passive tag front end, apb registers
// assumes event inputs are one-cycle pulses synchronous to CLK_I
`timescale 1ns/1ns
module tag_interrupt_mask_flags (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        NVM_PU_UNMASK_I,
    input  wire logic        NVM_ACT_UNMASK_I,
    input  wire logic        EV_POWER_UP_I,
    input  wire logic        EV_ACTIVE_ENTRY_I,
    input  wire logic        EV_WAKE_CMD_I,
    input  wire logic        EV_RX_START_I,
    input  wire logic        EV_RX_END_I,
    input  wire logic        RX_TO_FIFO_I,
    input  wire logic        EV_TX_END_I,
    input  wire logic        TX_FROM_FIFO_I,
    input  wire logic        RECEIVING_I,
    input  wire logic        TRANSMITTING_I,
    input  wire logic        FIFO_NEAR_FULL_I,
    input  wire logic        FIFO_NEAR_EMPTY_I,
    input  wire logic        EV_DESELECT_I,
    input  wire logic        EV_FRAMING_ERR_I,
    input  wire logic        EV_PARITY_ERR_I,
    input  wire logic        EV_CHECK_ERR_I,
    input  wire logic        FIFO_OVERFLOW_I,
    input  wire logic        FIFO_UNDERFLOW_I,
    input  wire logic        EV_NVM_WRITE_OK_I,
    input  wire logic        EV_NVM_WRITE_ERR_I,
    input  wire logic        EV_NVM_ABORT_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             IRQ_O
);
    logic [7:0]  main_mask_ff;
    logic [7:0]  nxt_main_mask;
    logic [7:0]  aux_mask_ff;
    logic [7:0]  nxt_aux_mask;
    logic [7:0]  main_flags_ff;
    logic [7:0]  nxt_main_flags;
    logic [7:0]  aux_flags_ff;
    logic [7:0]  nxt_aux_flags;
    logic        init_ff;
    logic        nxt_init;
    logic        wl_cond_ff;
    logic        nxt_wl_cond;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic        irq_ff;
    logic        nxt_irq;
    logic [7:0]  main_ev;
    logic [7:0]  aux_ev;
    logic        acc;
    logic        setdef;
    logic        rd_main;
    logic        rd_aux;
    logic        mapped;

    function automatic logic hit(input logic [31:0] a, input logic [7:0] i);
        return a == {22'h000000, i, 2'h0};
    endfunction

    assign acc    = PSEL_I && PENABLE_I && !pready_ff;
    assign mapped = hit(PADDR_I, tag_irq_pkg::MAIN_MASK_IDX)
                 || hit(PADDR_I, tag_irq_pkg::AUX_MASK_IDX)
                 || hit(PADDR_I, tag_irq_pkg::MAIN_FLAGS_IDX)
                 || hit(PADDR_I, tag_irq_pkg::AUX_FLAGS_IDX)
                 || hit(PADDR_I, tag_irq_pkg::CONTROL_IDX);
    assign setdef = acc && PWRITE_I
                 && hit(PADDR_I, tag_irq_pkg::CONTROL_IDX)
                 && PWDATA_I[tag_irq_pkg::SETDEF_BIT];
    assign rd_main = acc && !PWRITE_I
                  && hit(PADDR_I, tag_irq_pkg::MAIN_FLAGS_IDX);
    assign rd_aux  = acc && !PWRITE_I
                  && hit(PADDR_I, tag_irq_pkg::AUX_FLAGS_IDX);

    // event collection
    always_comb begin
        main_ev = 8'h00;
        aux_ev  = 8'h00;
        nxt_wl_cond = (RECEIVING_I && FIFO_NEAR_FULL_I)
                   || (TRANSMITTING_I && FIFO_NEAR_EMPTY_I);
        main_ev[tag_irq_pkg::PU_BIT]   = EV_POWER_UP_I;
        main_ev[tag_irq_pkg::ACT_BIT]  = EV_ACTIVE_ENTRY_I;
        main_ev[tag_irq_pkg::WAKE_BIT] = EV_WAKE_CMD_I;
        main_ev[tag_irq_pkg::RXS_BIT]  = EV_RX_START_I && RX_TO_FIFO_I;
        main_ev[tag_irq_pkg::RXE_BIT]  = EV_RX_END_I && RX_TO_FIFO_I;
        main_ev[tag_irq_pkg::TXE_BIT]  = EV_TX_END_I && TX_FROM_FIFO_I;
        main_ev[tag_irq_pkg::WL_BIT]   = nxt_wl_cond && !wl_cond_ff;
        aux_ev[tag_irq_pkg::DES_BIT]   = EV_DESELECT_I;
        aux_ev[tag_irq_pkg::FR_BIT]    = EV_FRAMING_ERR_I;
        aux_ev[tag_irq_pkg::PAR_BIT]   = EV_PARITY_ERR_I;
        aux_ev[tag_irq_pkg::CRC_BIT]   = EV_CHECK_ERR_I;
        aux_ev[tag_irq_pkg::QERR_BIT]  = FIFO_OVERFLOW_I
                                      || FIFO_UNDERFLOW_I;
        aux_ev[tag_irq_pkg::NVOK_BIT]  = EV_NVM_WRITE_OK_I;
        aux_ev[tag_irq_pkg::NVERR_BIT] = EV_NVM_WRITE_ERR_I;
        aux_ev[tag_irq_pkg::NVABT_BIT] = EV_NVM_ABORT_I;
    end

    // masks, flags and power-up init
    always_comb begin
        nxt_init      = 1'b0;
        nxt_main_mask = main_mask_ff;
        nxt_aux_mask  = aux_mask_ff;
        if (init_ff) begin
            if (NVM_PU_UNMASK_I)
                nxt_main_mask[tag_irq_pkg::PU_BIT] = 1'b0;
            if (NVM_ACT_UNMASK_I)
                nxt_main_mask[tag_irq_pkg::ACT_BIT] = 1'b0;
        end
        if (acc && PWRITE_I) begin
            if (hit(PADDR_I, tag_irq_pkg::MAIN_MASK_IDX))
                nxt_main_mask = PWDATA_I[7:0]
                              & tag_irq_pkg::MAIN_MASK_WR;
            if (hit(PADDR_I, tag_irq_pkg::AUX_MASK_IDX))
                nxt_aux_mask = PWDATA_I[7:0];
        end
        nxt_main_flags = main_flags_ff;
        nxt_aux_flags  = aux_flags_ff;
        if (rd_main)
            nxt_main_flags[7:1] = 7'h00;
        if (rd_aux)
            nxt_aux_flags = 8'h00;
        nxt_aux_flags  = nxt_aux_flags | aux_ev;
        nxt_main_flags = nxt_main_flags | main_ev;
        nxt_main_flags[tag_irq_pkg::AUX_BIT] = |nxt_aux_flags;
        if (setdef) begin
            nxt_main_mask  = tag_irq_pkg::MAIN_MASK_RST;
            nxt_aux_mask   = tag_irq_pkg::AUX_MASK_RST;
            nxt_main_flags = tag_irq_pkg::FLAGS_RST;
            nxt_aux_flags  = tag_irq_pkg::FLAGS_RST;
        end
        nxt_irq = |((nxt_main_flags & ~nxt_main_mask) & 8'hfe)
               || |(nxt_aux_flags & ~nxt_aux_mask);
    end

    // apb answer, one wait state
    always_comb begin
        nxt_pready  = acc;
        nxt_pslverr = acc && !mapped;
        nxt_prdata  = 32'h00000000;
        if (acc && !PWRITE_I) begin
            if (hit(PADDR_I, tag_irq_pkg::MAIN_MASK_IDX))
                nxt_prdata[7:0] = main_mask_ff;
            if (hit(PADDR_I, tag_irq_pkg::AUX_MASK_IDX))
                nxt_prdata[7:0] = aux_mask_ff;
            if (rd_main)
                nxt_prdata[7:0] = main_flags_ff;
            if (rd_aux)
                nxt_prdata[7:0] = aux_flags_ff;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            main_mask_ff  <= tag_irq_pkg::MAIN_MASK_RST;
            aux_mask_ff   <= tag_irq_pkg::AUX_MASK_RST;
            main_flags_ff <= tag_irq_pkg::FLAGS_RST;
            aux_flags_ff  <= tag_irq_pkg::FLAGS_RST;
            init_ff       <= 1'b1;
            wl_cond_ff    <= 1'b0;
            prdata_ff     <= 32'h00000000;
            pready_ff     <= 1'b0;
            pslverr_ff    <= 1'b0;
            irq_ff        <= 1'b0;
        end else begin
            main_mask_ff  <= nxt_main_mask;
            aux_mask_ff   <= nxt_aux_mask;
            main_flags_ff <= nxt_main_flags;
            aux_flags_ff  <= nxt_aux_flags;
            init_ff       <= nxt_init;
            wl_cond_ff    <= nxt_wl_cond;
            prdata_ff     <= nxt_prdata;
            pready_ff     <= nxt_pready;
            pslverr_ff    <= nxt_pslverr;
            irq_ff        <= nxt_irq;
        end
    end

    assign PRDATA_O  = prdata_ff;
    assign PREADY_O  = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign IRQ_O     = irq_ff;

    // checks
    chk_mask_reset: assert property (@(posedge CLK_I)
        $past(RST_I) && !RST_I |-> main_mask_ff[6:0] == 7'h40
                                 && aux_mask_ff == 8'h00)
        else $error("mask reset value wrong");
    chk_bit0_zero: assert property (@(posedge CLK_I)
        disable iff (RST_I) main_mask_ff[0] == 1'b0)
        else $error("reserved mask bit set");
    chk_pu_init: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        init_ff && NVM_PU_UNMASK_I && !setdef
        ##1 1'b1 |-> !main_mask_ff[7])
        else $error("power-up mask not cleared");
    chk_act_init: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        init_ff && NVM_ACT_UNMASK_I && !setdef
        ##1 1'b1 |-> !main_mask_ff[tag_irq_pkg::ACT_BIT])
        else $error("active-entry mask not cleared");
    chk_setdef: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        setdef |=> main_mask_ff == 8'hc0 && aux_mask_ff == 8'h00)
        else $error("set default missed");
    chk_main_mask_wr: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        acc && PWRITE_I && hit(PADDR_I, tag_irq_pkg::MAIN_MASK_IDX)
        |=> main_mask_ff == ($past(PWDATA_I[7:0])
                             & tag_irq_pkg::MAIN_MASK_WR))
        else $error("main mask write lost");
    chk_aux_mask_wr: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        acc && PWRITE_I && hit(PADDR_I, tag_irq_pkg::AUX_MASK_IDX)
        |=> aux_mask_ff == $past(PWDATA_I[7:0]))
        else $error("aux mask write lost");
    chk_read_clear: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        rd_main && !setdef |=> (main_flags_ff[7:1] & ~$past(main_ev[7:1]))
                               == 7'h00)
        else $error("flags not cleared on read");
    chk_aux_clear: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        rd_aux && aux_ev == 8'h00 |=> !main_flags_ff[tag_irq_pkg::AUX_BIT])
        else $error("summary bit not cleared");
    chk_summary: assert property (@(posedge CLK_I)
        disable iff (RST_I) main_flags_ff[0] == (|aux_flags_ff))
        else $error("summary bit mismatch");
    chk_flags_ro: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        acc && PWRITE_I && hit(PADDR_I, tag_irq_pkg::MAIN_FLAGS_IDX)
        && main_ev == 8'h00 && aux_ev == 8'h00
        |=> main_flags_ff == $past(main_flags_ff))
        else $error("flag register written");
    chk_pu_flag: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        EV_POWER_UP_I && !setdef |=> main_flags_ff[tag_irq_pkg::PU_BIT])
        else $error("power-up flag lost");
    chk_act_flag: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        EV_ACTIVE_ENTRY_I && !setdef |=> main_flags_ff[tag_irq_pkg::ACT_BIT])
        else $error("active-entry flag lost");
    chk_wake_flag: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        EV_WAKE_CMD_I && !setdef |=> main_flags_ff[tag_irq_pkg::WAKE_BIT])
        else $error("wake command flag lost");
    chk_rx_gate: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        EV_RX_END_I && RX_TO_FIFO_I |=> main_flags_ff[3])
        else $error("rx end flag lost");
    chk_rxs_gate: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        !main_flags_ff[tag_irq_pkg::RXS_BIT]
        && !(EV_RX_START_I && RX_TO_FIFO_I)
        |=> !main_flags_ff[tag_irq_pkg::RXS_BIT])
        else $error("rx start flag without cause");
    chk_tx_gate: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        !main_flags_ff[2] && !(EV_TX_END_I && TX_FROM_FIFO_I)
        |=> !main_flags_ff[2])
        else $error("tx end flag without cause");
    chk_tx_flag: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        EV_TX_END_I && TX_FROM_FIFO_I && !setdef
        |=> main_flags_ff[tag_irq_pkg::TXE_BIT])
        else $error("tx end flag lost");
    chk_wl_flag: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        $rose((RECEIVING_I && FIFO_NEAR_FULL_I)
              || (TRANSMITTING_I && FIFO_NEAR_EMPTY_I)) && !setdef
        |=> main_flags_ff[tag_irq_pkg::WL_BIT])
        else $error("water level flag lost");
    chk_par_flag: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        EV_PARITY_ERR_I && !setdef |=> aux_flags_ff[tag_irq_pkg::PAR_BIT])
        else $error("parity error flag lost");
    chk_crc_flag: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        EV_CHECK_ERR_I && !setdef |=> aux_flags_ff[tag_irq_pkg::CRC_BIT])
        else $error("check error flag lost");
    chk_queue_err: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        (FIFO_OVERFLOW_I || FIFO_UNDERFLOW_I) && !setdef
        |=> aux_flags_ff[3] && (IRQ_O || aux_mask_ff[3]))
        else $error("queue error not flagged");
    chk_irq_out: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        IRQ_O == (|((main_flags_ff & ~main_mask_ff) & 8'hfe)
               || |(aux_flags_ff & ~aux_mask_ff)))
        else $error("irq output mismatch");
    chk_irq_set: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        main_flags_ff[tag_irq_pkg::WAKE_BIT]
        && !main_mask_ff[tag_irq_pkg::WAKE_BIT] |-> IRQ_O)
        else $error("unmasked flag gives no irq");
    cov_main_read: cover property (@(posedge CLK_I) rd_main && IRQ_O);
    cov_aux_read: cover property (@(posedge CLK_I) rd_aux && main_flags_ff[0]);
    cov_setdef: cover property (@(posedge CLK_I) setdef);
    cov_wl: cover property (@(posedge CLK_I) main_ev[1]);
    cov_nvm_init: cover property (@(posedge CLK_I) init_ff && NVM_PU_UNMASK_I);
endmodule

// ===== src/tag_irq_pkg.sv
// register map and bit layout of the tag interrupt flag and mask block
// assumes a 32-bit apb slave port with byte addresses
package tag_irq_pkg;
    localparam logic [7:0] MAIN_MASK_IDX  = 8'h08;
    localparam logic [7:0] AUX_MASK_IDX   = 8'h09;
    localparam logic [7:0] MAIN_FLAGS_IDX = 8'h0a;
    localparam logic [7:0] AUX_FLAGS_IDX  = 8'h0b;
    localparam logic [7:0] CONTROL_IDX    = 8'h0e;
    localparam logic [7:0] MAIN_MASK_RST  = 8'hc0;
    localparam logic [7:0] AUX_MASK_RST   = 8'h00;
    localparam logic [7:0] FLAGS_RST      = 8'h00;
    localparam logic [7:0] MAIN_MASK_WR   = 8'hfe;
    localparam int         PU_BIT         = 7;
    localparam int         ACT_BIT        = 6;
    localparam int         WAKE_BIT       = 5;
    localparam int         RXS_BIT        = 4;
    localparam int         RXE_BIT        = 3;
    localparam int         TXE_BIT        = 2;
    localparam int         WL_BIT         = 1;
    localparam int         AUX_BIT        = 0;
    localparam int         DES_BIT        = 7;
    localparam int         FR_BIT         = 6;
    localparam int         PAR_BIT        = 5;
    localparam int         CRC_BIT        = 4;
    localparam int         QERR_BIT       = 3;
    localparam int         NVOK_BIT       = 2;
    localparam int         NVERR_BIT      = 1;
    localparam int         NVABT_BIT      = 0;
    localparam int         SETDEF_BIT     = 0;
endpackage

// ===== testbench/tag_host_model.sv
// host side model: apb master that reads flags and sets masks
// assumes one clock; the bench calls xfer by hierarchical name
`timescale 1ns/1ns
module tag_host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [31:0] paddr_o,
    output logic      [31:0] pwdata_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 32'h0;
        pwdata_o = 32'h0;
    end

    // one transfer; ok stays low if no answer comes within the bound
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err, output logic ok);
        int n;
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= {22'h0, idx, 2'b00};
        pwdata_o <= wd;
        @(posedge clk_i);
        penable_o <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_i);
            ok = (pready_i === 1'b1);
        end
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~paddr_o;
        pwdata_o <= ~pwdata_o;
    endtask
endmodule

// ===== testbench/test_tag_interrupt_mask_flags.sv
// self-checking bench for the tag interrupt flag and mask block
// assumes the host model drives apb; events and levels come from here
`timescale 1ns/1ns
module test_tag_interrupt_mask_flags;
    logic        clk, rst, psel, pen, pwr, rdy, err, irq, last_err;
    logic [14:0] ev;
    logic [7:0]  lv;
    logic [31:0] paddr, pwdata, prdata;
    int          num_errors;
    int          num_checks;

    tag_interrupt_mask_flags dut_u (
        .CLK_I(clk), .RST_I(rst), .NVM_PU_UNMASK_I(lv[6]),
        .NVM_ACT_UNMASK_I(lv[7]), .EV_POWER_UP_I(ev[0]),
        .EV_ACTIVE_ENTRY_I(ev[1]), .EV_WAKE_CMD_I(ev[2]),
        .EV_RX_START_I(ev[3]), .EV_RX_END_I(ev[4]),
        .RX_TO_FIFO_I(lv[0]), .EV_TX_END_I(ev[5]),
        .TX_FROM_FIFO_I(lv[1]), .RECEIVING_I(lv[2]),
        .TRANSMITTING_I(lv[3]), .FIFO_NEAR_FULL_I(lv[4]),
        .FIFO_NEAR_EMPTY_I(lv[5]), .EV_DESELECT_I(ev[6]),
        .EV_FRAMING_ERR_I(ev[7]), .EV_PARITY_ERR_I(ev[8]),
        .EV_CHECK_ERR_I(ev[9]), .FIFO_OVERFLOW_I(ev[10]),
        .FIFO_UNDERFLOW_I(ev[11]), .EV_NVM_WRITE_OK_I(ev[12]),
        .EV_NVM_WRITE_ERR_I(ev[13]), .EV_NVM_ABORT_I(ev[14]),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(rdy),
        .PSLVERR_O(err), .IRQ_O(irq));

    tag_host_model host_u (
        .clk_i(clk), .prdata_i(prdata), .pready_i(rdy), .pslverr_i(err),
        .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr),
        .pwdata_o(pwdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        num_checks++;
        if (got !== e) begin
            num_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic ok;
        host_u.xfer(w, idx, wd, rd, last_err, ok);
        if (ok !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        chk(rd, e);
    endtask

    task automatic do_reset(input logic [1:0] nv);
        @(posedge clk);
        rst <= 1'b1;
        lv <= {nv, 6'h00};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 15'(1) << i;
        @(posedge clk);
        ev <= '0;
        @(negedge clk);
    endtask

    task automatic setlv(input logic [7:0] v);
        @(posedge clk);
        lv <= v;
    endtask

    task automatic t_regs();
        rdchk(tag_irq_pkg::MAIN_MASK_IDX, 32'hc0);
        chk(32'(last_err), 32'h0);
        rdchk(tag_irq_pkg::AUX_MASK_IDX, 32'h0);
        rdchk(8'h3f, 32'h0);
        chk(32'(last_err), 32'h1);
        wr(tag_irq_pkg::MAIN_MASK_IDX, 32'hff);
        rdchk(tag_irq_pkg::MAIN_MASK_IDX, 32'hfe);
        wr(tag_irq_pkg::AUX_MASK_IDX, 32'ha5);
        rdchk(tag_irq_pkg::AUX_MASK_IDX, 32'ha5);
        wr(tag_irq_pkg::MAIN_FLAGS_IDX, 32'hff);
        rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h0);
        wr(tag_irq_pkg::CONTROL_IDX, 32'h1);
        rdchk(tag_irq_pkg::MAIN_MASK_IDX, 32'hc0);
        rdchk(tag_irq_pkg::AUX_MASK_IDX, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_main();
        int i;
        setlv(8'h03);
        for (i = 0; i < 6; i++) begin
            pulse(i);
            chk(32'(irq), (i > 1) ? 32'h1 : 32'h0);
            rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h1 << (7 - i));
            chk(32'(irq), 32'h0);
        end
        setlv(8'h00);
        for (i = 3; i < 6; i++) begin
            pulse(i);
        end
        rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h0);
        wr(tag_irq_pkg::MAIN_MASK_IDX, 32'h20);
        pulse(2);
        chk(32'(irq), 32'h0);
        wr(tag_irq_pkg::MAIN_MASK_IDX, 32'h00);
        repeat (2) @(negedge clk);
        chk(32'(irq), 32'h1);
        rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h20);
        $display("test main flags done");
    endtask

    task automatic t_water();
        setlv(8'h14);
        setlv(8'h00);
        rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h02);
        setlv(8'h28);
        setlv(8'h00);
        rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h02);
        setlv(8'h24);
        setlv(8'h00);
        rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h00);
        $display("test water level done");
    endtask

    task automatic t_aux();
        int i;
        for (i = 6; i < 15; i++) begin
            pulse(i);
            chk(32'(irq), 32'h1);
            rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h1);
            rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h1);
            rdchk(tag_irq_pkg::AUX_FLAGS_IDX,
                  32'h1 << ((i < 11) ? 13 - i : 14 - i));
            rdchk(tag_irq_pkg::MAIN_FLAGS_IDX, 32'h0);
        end
        wr(tag_irq_pkg::AUX_MASK_IDX, 32'hff);
        pulse(6);
        chk(32'(irq), 32'h0);
        $display("test aux flags done");
    endtask

    task automatic t_nvm();
        do_reset(2'b11);
        rdchk(tag_irq_pkg::MAIN_MASK_IDX, 32'h0);
        rdchk(tag_irq_pkg::AUX_MASK_IDX, 32'h0);
        pulse(0);
        chk(32'(irq), 32'h1);
        $display("test nvm unmask done");
    endtask

    initial begin
        rst = 1'b1;
        ev = '0;
        lv = '0;
        num_errors = 0;
        num_checks = 0;
        do_reset(2'b00);
        t_regs();
        t_main();
        t_water();
        t_aux();
        t_nvm();
        stop_test();
    end
endmodule
